/* logic/serial_prog_mode_responder.sv */
// The Wishbone register port and the address map were decided locally.
`timescale 1ns/100ps
`include "spm_consts.svh"

module serial_prog_mode_responder
    import spm_pkg::*;
#(
    parameter int         PORT_W     = 8,
    parameter int         UART_A_IDX = 3,
    parameter int         UART_B_IDX = 2,
    parameter logic [7:0] RSVD_ID    = 8'h5A   // Arbitrary value
) (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // Command request from the link parser
    input  wire logic              cmd_valid_i,
    input  wire cmd_req_t          cmd_i,
    input  wire logic              pw_match_i,
    output logic                   cmd_ready_o,
    // Flash state
    input  wire logic              security_i,
    input  wire logic              nonblank_i,
    // Reply byte stream
    output logic                   tx_valid_o,
    output logic      [7:0]        tx_data_o,
    input  wire logic              tx_ready_i,
    // Command execution
    output logic                   exec_o,
    output cmd_kind_t              exec_kind_o,
    output logic                   erase_o,
    output erase_req_t             erase_req_o,
    output logic                   halted_o,
    // Ports
    input  wire logic              serial_mode_i,
    input  wire logic [PORT_W-1:0] port_pin_i,
    output logic      [PORT_W-1:0] port_in_o,
    output logic                   periph_in_valid_o
);

    if (PORT_W < 2 || UART_A_IDX >= PORT_W || UART_B_IDX >= PORT_W ||
        UART_A_IDX == UART_B_IDX) begin : g_bad_params
        $error("serial_prog_mode_responder: bad port parameters");
    end

    // ----------------------------------------
    // Reply byte tables
    // ----------------------------------------
    localparam logic [15:0] ROM_FIRST = `SPM_ROM_FIRST;

    function automatic logic [7:0] id_sum();
        logic [7:0] s;
        s = `SPM_ID_ADDR_LEN + RSVD_ID + `SPM_ID_BLOCKS
            + ROM_FIRST[15:8] + ROM_FIRST[7:0]
            + `SPM_ID_LAST_HI + `SPM_ID_LAST_LO;
        return 8'h00 - s;
    endfunction

    function automatic logic [7:0] id_byte(input logic [3:0] i);
        case (i)
            4'h0:    return `SPM_START_MARK;
            4'h1:    return `SPM_ID_COUNT;
            4'h2:    return `SPM_ID_ADDR_LEN;
            4'h3:    return RSVD_ID;
            4'h7:    return `SPM_ID_BLOCKS;
            4'h8:    return ROM_FIRST[15:8];
            4'h9:    return ROM_FIRST[7:0];
            4'hA:    return `SPM_ID_LAST_HI;
            4'hB:    return `SPM_ID_LAST_LO;
            4'hC:    return id_sum();
            default: return `SPM_ZERO_BYTE;
        endcase
    endfunction

    function automatic logic [7:0] st_byte(input logic [3:0] i,
                                           input logic [7:0] code);
        case (i)
            4'h0:    return `SPM_START_MARK;
            4'h1:    return `SPM_ST_COUNT;
            4'h2:    return code;
            4'h6:    return 8'h00 - code;
            default: return `SPM_ZERO_BYTE;
        endcase
    endfunction

    // ----------------------------------------
    // Command gating
    // ----------------------------------------
    function automatic decision_t gate(input cmd_kind_t k,
                                       input logic sec,
                                       input logic nb,
                                       input logic pw,
                                       input logic chip);
        logic need_pw;
        logic refuse;
        need_pw = 1'b0;
        refuse  = 1'b0;
        case (k)
            CMD_FLASH_WRITE, CMD_RAM_LOADER: begin
                refuse  = sec;
                need_pw = nb;
            end
            CMD_ERASE: begin
                refuse  = sec && !chip;
                need_pw = nb;
            end
            CMD_SEC_SET: begin
                refuse  = !nb;
                need_pw = 1'b1;
            end
            default: begin
                refuse  = 1'b0;
                need_pw = 1'b0;
            end
        endcase
        if (refuse)
            return DEC_REFUSE;
        else if (need_pw && !pw)
            return DEC_PWFAIL;
        else
            return DEC_EXEC;
    endfunction

    logic       accept;
    logic       is_chip;
    logic       out_of_flash;
    decision_t  dec;
    logic [7:0] status_code;

    assign accept  = cmd_valid_i && cmd_ready_o;
    // Start above end means chip erase
    assign is_chip = cmd_i.erase_start_addr > cmd_i.erase_end_addr;
    // Flash ends at the top of the space, only the low end can miss
    assign out_of_flash = cmd_i.erase_start_addr < ROM_FIRST;
    assign dec = gate(cmd_i.kind, security_i, nonblank_i, pw_match_i,
                      is_chip);
    assign status_code = {6'h00, nonblank_i, security_i};

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    state_t     state_q;
    state_t     state_d;
    logic [3:0] idx_q;
    cmd_kind_t  kind_q;
    logic [7:0] code_q;
    logic       tx_done;
    logic [3:0] last_idx;

    assign tx_done  = tx_valid_o && tx_ready_i;
    assign last_idx = (kind_q == CMD_PROD_ID) ? `SPM_ID_LEN - 4'h1
                                              : `SPM_ST_LEN - 4'h1;

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (accept) begin
                    if (dec == DEC_REFUSE)
                        state_d = ST_ECHO;
                    else if (dec == DEC_PWFAIL)
                        state_d = ST_HALT;
                    else if (cmd_i.kind == CMD_ERASE && !is_chip &&
                             out_of_flash)
                        state_d = ST_HALT;
                    else if (cmd_i.kind == CMD_PROD_ID ||
                             cmd_i.kind == CMD_STATUS_OUT)
                        state_d = ST_SEND;
                end
            end
            ST_SEND: begin
                if (tx_done && idx_q == last_idx)
                    state_d = ST_IDLE;
            end
            ST_ECHO: begin
                if (tx_done)
                    state_d = ST_HALT;
            end
            ST_HALT:  state_d = ST_HALT;
            default:  state_d = ST_HALT;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q     <= ST_IDLE;
            cmd_ready_o <= 1'b0;
            halted_o    <= 1'b0;
        end else begin
            state_q     <= state_d;
            cmd_ready_o <= state_d == ST_IDLE;
            halted_o    <= state_d == ST_HALT;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            kind_q <= CMD_FLASH_WRITE;
            code_q <= 8'h00;
        end else if (accept) begin
            kind_q <= cmd_i.kind;
            code_q <= cmd_i.code;
        end
    end

    // Status code is frozen at acceptance so the checksum matches
    logic [7:0] st_code_q;
    always_ff @(posedge clk_i) begin
        if (rst_i)
            st_code_q <= 8'h00;
        else if (accept)
            st_code_q <= status_code;
    end

    // ----------------------------------------
    // Reply byte stream
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_valid_o <= 1'b0;
            tx_data_o  <= 8'h00;
            idx_q      <= 4'h0;
        end else if (state_q == ST_IDLE && state_d == ST_ECHO) begin
            tx_valid_o <= 1'b1;
            tx_data_o  <= cmd_i.code;
        end else if (state_q == ST_IDLE && state_d == ST_SEND) begin
            tx_valid_o <= 1'b1;
            idx_q      <= 4'h0;
            tx_data_o  <= `SPM_START_MARK;
        end else if (state_q == ST_SEND && tx_done) begin
            if (idx_q == last_idx) begin
                tx_valid_o <= 1'b0;
            end else begin
                idx_q     <= idx_q + 4'h1;
                tx_data_o <= (kind_q == CMD_PROD_ID)
                           ? id_byte(idx_q + 4'h1)
                           : st_byte(idx_q + 4'h1, st_code_q);
            end
        end else if (state_q == ST_ECHO && tx_done) begin
            tx_valid_o <= 1'b0;
        end
    end

    // ----------------------------------------
    // Execution strobes
    // ----------------------------------------
    logic go;
    assign go = accept && state_d == ST_IDLE && dec == DEC_EXEC;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            exec_o      <= 1'b0;
            exec_kind_o <= CMD_FLASH_WRITE;
            erase_o     <= 1'b0;
            erase_req_o <= '0;
        end else begin
            exec_o  <= go;
            erase_o <= go && cmd_i.kind == CMD_ERASE;
            if (go) begin
                exec_kind_o <= cmd_i.kind;
            end
            if (go && cmd_i.kind == CMD_ERASE) begin
                erase_req_o.chip <= is_chip;
                erase_req_o.first_sector <=
                    cmd_i.erase_start_addr[`SPM_SECTOR_MSB:`SPM_SECTOR_LSB];
                erase_req_o.last_sector <=
                    cmd_i.erase_end_addr[`SPM_SECTOR_MSB:`SPM_SECTOR_LSB];
            end
        end
    end

    // ----------------------------------------
    // Port input gating
    // ----------------------------------------
    logic [PORT_W-1:0] pin_meta_q;
    logic [PORT_W-1:0] pin_sync_q;
    logic              mode_meta_q;
    logic              mode_q;
    logic [7:0]        port_ctrl_q;
    logic [PORT_W-1:0] link_mask;

    always_comb begin
        link_mask = '0;
        link_mask[UART_A_IDX] = 1'b1;
        link_mask[UART_B_IDX] = 1'b1;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_meta_q  <= '0;
            pin_sync_q  <= '0;
            mode_meta_q <= 1'b0;
            mode_q      <= 1'b0;
        end else begin
            pin_meta_q  <= port_pin_i;
            pin_sync_q  <= pin_meta_q;
            mode_meta_q <= serial_mode_i;
            mode_q      <= mode_meta_q;
        end
    end

    logic ports_open;
    assign ports_open = !mode_q || port_ctrl_q[`SPM_PORT_EN_BIT];

    // Fixed low keeps floating unused pins from drawing overlap current
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_in_o         <= '0;
            periph_in_valid_o <= 1'b0;
        end else begin
            port_in_o <= ports_open ? pin_sync_q
                                    : (pin_sync_q & link_mask);
            periph_in_valid_o <= ports_open;
        end
    end

    // ----------------------------------------
    // Wishbone register file
    // ----------------------------------------
    logic wb_req;
    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

    always_ff @(posedge clk_i) begin
        if (rst_i)
            port_ctrl_q <= `SPM_PORT_CTRL_RST;
        else if (wb_req && wb_we_i && wb_sel_i[0] && mode_q &&
                 wb_adr_i == `SPM_OFS_PORT_CTRL)
            port_ctrl_q <= wb_dat_i[7:0];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= 32'h0000_0000;
            if (wb_req && !wb_we_i) begin
                case (wb_adr_i)
                    `SPM_OFS_PORT_CTRL:
                        wb_dat_o[7:0] <= mode_q ? port_ctrl_q
                            : {7'h00, port_ctrl_q[0]};
                    `SPM_OFS_STATUS: begin
                        wb_dat_o[`SPM_ST_SEC_BIT]  <= security_i;
                        wb_dat_o[`SPM_ST_NB_BIT]   <= nonblank_i;
                        wb_dat_o[`SPM_ST_HALT_BIT] <= halted_o;
                        wb_dat_o[`SPM_ST_MODE_BIT] <= mode_q;
                    end
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    logic [7:0] sum_q;
    logic [3:0] cnt_q;
    always_ff @(posedge clk_i) begin
        if (rst_i || state_q != ST_SEND) begin
            sum_q <= 8'h00;
            cnt_q <= 4'h0;
        end else if (tx_done) begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q >= `SPM_SUM_FIRST_IDX)
                sum_q <= sum_q + tx_data_o;
        end
    end

    property p_id_len;
        @(posedge clk_i) disable iff (rst_i)
        (state_q == ST_SEND && kind_q == CMD_PROD_ID && tx_done &&
         state_d == ST_IDLE) |-> cnt_q == 4'hC;
    endproperty
    a_id_len: assert property (p_id_len)
        else $error("id reply length");

    property p_st_len;
        @(posedge clk_i) disable iff (rst_i)
        (state_q == ST_SEND && kind_q == CMD_STATUS_OUT && tx_done &&
         state_d == ST_IDLE) |-> cnt_q == 4'h6;
    endproperty
    a_st_len: assert property (p_st_len)
        else $error("status length");

    property p_head;
        @(posedge clk_i) disable iff (rst_i)
        (state_q == ST_SEND && tx_valid_o && idx_q < 4'h2) |->
        tx_data_o == (idx_q == 4'h0 ? `SPM_START_MARK
                      : kind_q == CMD_PROD_ID ? `SPM_ID_COUNT
                      : `SPM_ST_COUNT);
    endproperty
    a_head: assert property (p_head)
        else $error("reply header");

    property p_sum;
        @(posedge clk_i) disable iff (rst_i)
        (state_q == ST_SEND && tx_done && state_d == ST_IDLE) |->
        8'(sum_q + tx_data_o) == 8'h00;
    endproperty
    a_sum: assert property (p_sum)
        else $error("reply checksum");

    property p_echo;
        @(posedge clk_i) disable iff (rst_i)
        (accept && dec == DEC_REFUSE) |=>
        tx_valid_o && tx_data_o == $past(cmd_i.code) && state_q == ST_ECHO;
    endproperty
    a_echo: assert property (p_echo)
        else $error("refused not echoed");

    property p_halt;
        @(posedge clk_i) disable iff (rst_i)
        halted_o |=> halted_o && !tx_valid_o && !cmd_ready_o [*2];
    endproperty
    a_halt: assert property (p_halt)
        else $error("halt not held");

    property p_sector_sec;
        @(posedge clk_i) disable iff (rst_i)
        (accept && cmd_i.kind == CMD_ERASE && security_i && !is_chip)
        |=> !erase_o;
    endproperty
    a_sector_sec: assert property (p_sector_sec)
        else $error("sector erase while secured");

    property p_chip;
        @(posedge clk_i) disable iff (rst_i)
        (go && cmd_i.kind == CMD_ERASE &&
         cmd_i.erase_start_addr > cmd_i.erase_end_addr)
        |=> erase_o && erase_req_o.chip;
    endproperty
    a_chip: assert property (p_chip)
        else $error("chip erase missed");

    property p_gate;
        @(posedge clk_i) disable iff (rst_i)
        ($past(mode_q) && !$past(port_ctrl_q[0]))
        |-> (port_in_o & ~link_mask) == '0 && !periph_in_valid_o;
    endproperty
    a_gate: assert property (p_gate)
        else $error("ports not fixed");

    property p_pwfail;
        @(posedge clk_i) disable iff (rst_i)
        (accept && dec == DEC_PWFAIL) |=> halted_o && !tx_valid_o;
    endproperty
    a_pwfail: assert property (p_pwfail)
        else $error("password gate");

endmodule

/* logic/spm_consts.svh */
`ifndef SPM_CONSTS_SVH
`define SPM_CONSTS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define SPM_OFS_PORT_CTRL   8'h00
`define SPM_OFS_STATUS      8'h04

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define SPM_PORT_EN_BIT     0
`define SPM_PORT_CTRL_RST   8'h00
`define SPM_ST_SEC_BIT      0
`define SPM_ST_NB_BIT       1
`define SPM_ST_HALT_BIT     2
`define SPM_ST_MODE_BIT     3

// ----------------------------------------
// Reply framing
// ----------------------------------------
`define SPM_START_MARK      8'h3A
`define SPM_ID_COUNT        8'h0A
`define SPM_ID_ADDR_LEN     8'h02
`define SPM_ID_BLOCKS       8'h01
`define SPM_ID_LAST_HI      8'hFF
`define SPM_ID_LAST_LO      8'hFF
`define SPM_ST_COUNT        8'h04
`define SPM_ZERO_BYTE       8'h00
`define SPM_ID_LEN          4'hD
`define SPM_ST_LEN          4'h7
`define SPM_SUM_FIRST_IDX   4'h2

// ----------------------------------------
// Flash geometry
// ----------------------------------------
`define SPM_ROM_FIRST       16'hC000
`define SPM_SECTOR_MSB      15
`define SPM_SECTOR_LSB      12

`endif

/* logic/spm_pkg.sv */
package spm_pkg;

    typedef enum logic [2:0] {
        CMD_FLASH_WRITE = 3'b000,
        CMD_RAM_LOADER  = 3'b001,
        CMD_SUM_OUT     = 3'b010,
        CMD_PROD_ID     = 3'b011,
        CMD_STATUS_OUT  = 3'b100,
        CMD_ERASE       = 3'b101,
        CMD_SEC_SET     = 3'b110
    } cmd_kind_t;

    typedef enum logic [1:0] {
        DEC_EXEC   = 2'b00,
        DEC_REFUSE = 2'b01,
        DEC_PWFAIL = 2'b10
    } decision_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SEND = 2'b01,
        ST_ECHO = 2'b10,
        ST_HALT = 2'b11
    } state_t;

    typedef struct packed {
        cmd_kind_t   kind;
        logic [7:0]  code;
        logic [15:0] erase_start_addr;
        logic [15:0] erase_end_addr;
    } cmd_req_t;

    typedef struct packed {
        logic       chip;
        logic [3:0] first_sector;
        logic [3:0] last_sector;
    } erase_req_t;

endpackage

/* tb/prog_ctrl_model.sv */
`timescale 1ns/100ps
module prog_ctrl_model (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Reply stream from the device
    input  wire logic       tx_valid_i,
    input  wire logic [7:0] tx_data_i,
    input  wire logic       slow_i,
    output logic            tx_ready_o
);
    logic [7:0] rx_q[$];
    logic [4:0] lfsr_q;

    // A slow controller stalls on a pseudo-random pattern
    always_ff @(posedge clk_i) begin
        lfsr_q <= rst_i ? 5'h1F : {lfsr_q[3:0], lfsr_q[4] ^ lfsr_q[2]};
    end
    // Plain always: the bench empties the queue between cases
    always @(posedge clk_i) begin
        if (!rst_i && tx_valid_i && tx_ready_o) begin
            rx_q.push_back(tx_data_i);
        end
    end
    assign tx_ready_o = !slow_i || lfsr_q[0];
endmodule

/* tb/tb.sv */
`timescale 1ns/100ps
`include "spm_consts.svh"
module tb
    import spm_pkg::*;
();
    localparam logic [7:0] RSVD = 8'h4B;   // Arbitrary value
    logic        clk_i = 0, rst_i = 1, slow = 0, saw_exec = 0, saw_erase = 0;
    logic        wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, cmd_valid_i = 0;
    logic        pw_match_i = 0, security_i = 0, nonblank_i = 0;
    logic        serial_mode_i = 0, wb_ack_o, cmd_ready_o, tx_valid_o;
    logic        tx_ready_i, exec_o, erase_o, halted_o, periph_in_valid_o;
    logic [7:0]  wb_adr_i = 0, port_pin_i = 0, tx_data_o, port_in_o, pins;
    logic [3:0]  wb_sel_i = 0;
    logic [31:0] wb_dat_i = 0, wb_dat_o, rd;
    logic [15:0] s, e;
    cmd_req_t    cmd_i = '0;
    cmd_kind_t   exec_kind_o, k;
    erase_req_t  erase_req_o;
    int          fails = 0, num_checks = 0, seed = 94, d;

    always #12.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        if (exec_o === 1'b1) saw_exec <= 1;
        if (erase_o === 1'b1) saw_erase <= 1;
    end

    serial_prog_mode_responder #(.RSVD_ID(RSVD)) serial_prog_mode_responder_inst (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .pw_match_i(pw_match_i),
        .cmd_ready_o(cmd_ready_o), .security_i(security_i),
        .nonblank_i(nonblank_i), .tx_valid_o(tx_valid_o),
        .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i), .exec_o(exec_o),
        .exec_kind_o(exec_kind_o), .erase_o(erase_o),
        .erase_req_o(erase_req_o), .halted_o(halted_o),
        .serial_mode_i(serial_mode_i), .port_pin_i(port_pin_i),
        .port_in_o(port_in_o), .periph_in_valid_o(periph_in_valid_o));
    prog_ctrl_model prog_ctrl_model_inst (.clk_i(clk_i), .rst_i(rst_i),
        .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o), .slow_i(slow),
        .tx_ready_o(tx_ready_i));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [7:0] rx(input int i);
        return prog_ctrl_model_inst.rx_q[i];
    endfunction
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Halts last until reset, so every refusal case starts afresh
    task automatic do_reset();
        rst_i <= 1;
        saw_exec <= 0;
        saw_erase <= 0;
        prog_ctrl_model_inst.rx_q.delete();
        repeat (16) @(posedge clk_i);
        rst_i <= 0;
        repeat (2) @(posedge clk_i);
    endtask
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] dt, input logic [3:0] sl);
        @(posedge clk_i);
        wb_cyc_i <= 1;
        wb_stb_i <= 1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= dt;
        wb_sel_i <= sl;
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 0;
        wb_stb_i <= 0;
    endtask
    task automatic send_cmd(input cmd_kind_t kk, input logic [15:0] a,
                            input logic [15:0] b);
        @(posedge clk_i);
        cmd_valid_i <= 1;
        cmd_i <= '{kk, {5'h14, kk}, a, b};
        do begin
            @(posedge clk_i);
        end while (cmd_ready_o !== 1'b1);
        cmd_valid_i <= 0;
    endtask
    // Only the watchdog ends a wait that never finishes
    task automatic wait_end(input int len);
        do begin
            @(posedge clk_i);
        end while (len == 0 ? (!saw_exec && halted_o !== 1'b1) :
                   (prog_ctrl_model_inst.rx_q.size() < len ||
                    cmd_ready_o !== 1'b1));
    endtask
    function automatic int decide(cmd_kind_t kk, logic sc, logic nb,
                                  logic pw, logic chip);
        if (kk == CMD_SEC_SET) return !nb ? 1 : (pw ? 0 : 2);
        if (kk == CMD_SUM_OUT) return 0;
        if (sc && !(kk == CMD_ERASE && chip)) return 1;
        return (nb && !pw) ? 2 : 0;
    endfunction
    function automatic logic [7:0] id_byte(int b);
        logic [7:0] t[13];
        logic [7:0] sum;
        t = '{8'h3A, 8'h0A, 8'h02, RSVD, 8'h00, 8'h00, 8'h00, 8'h01,
              `SPM_ROM_FIRST >> 8, 8'h00, 8'hFF, 8'hFF, 8'h00};
        sum = 8'h00;
        for (int i = 2; i < 12; i++) sum += t[i];
        t[12] = 8'h00 - sum;
        return t[b];
    endfunction

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        do_reset();
        for (int f = 0; f < 4; f++) begin
            {nonblank_i, security_i} <= 2'(f);
            slow <= f[0];
            prog_ctrl_model_inst.rx_q.delete();
            send_cmd(CMD_STATUS_OUT, 0, 0);
            send_cmd(CMD_PROD_ID, 0, 0);
            wait_end(20);
            check(prog_ctrl_model_inst.rx_q.size(), 20);
            for (int b = 0; b < 7; b++) begin
                rd = b == 0 ? 8'h3A : b == 1 ? 8'h04 : b == 2 ? f
                   : b == 6 ? 8'h00 - 8'(f) : 8'h00;
                check(rx(b), rd[7:0]);
            end
            for (int b = 0; b < 13; b++)
                check(rx(7+b), id_byte(b));
        end
        $display("test replies done");
        for (int i = 0; i < 112; i++) begin
            k = cmd_kind_t'(i % 7);
            if (k == CMD_PROD_ID || k == CMD_STATUS_OUT) continue;
            {security_i, nonblank_i, pw_match_i} <= 3'(i / 7);
            slow <= 1'($random(seed));
            s = 16'hC000 | 16'($random(seed));
            e = 16'hC000 | 16'($random(seed));
            if ((s > e) != (i >= 56)) {s, e} = {e, s};
            do_reset();
            send_cmd(k, s, e);
            wait_end(0);
            d = decide(k, security_i, nonblank_i, pw_match_i, s > e);
            check(saw_exec, d == 0);
            check(halted_o, d != 0);
            check(prog_ctrl_model_inst.rx_q.size(), d == 1);
            if (d == 1) check(rx(0), {5'h14, k});
            if (d == 0) check(exec_kind_o, k);
            if (d == 0 && k == CMD_ERASE) begin
                check(saw_erase, 1);
                check(erase_req_o, {s>e, s[15:12], e[15:12]});
            end
        end
        $display("test command gating done");
        {security_i, nonblank_i, pw_match_i} <= 3'b000;
        do_reset();
        send_cmd(CMD_ERASE, 16'h1000, 16'h2000);
        wait_end(0);
        check(halted_o, 1);
        check(saw_erase, 0);
        $display("test bad sector range done");
        pins = 8'($random(seed));
        port_pin_i <= pins;
        serial_mode_i <= 1;
        security_i <= 1;
        do_reset();
        wb(0, `SPM_OFS_PORT_CTRL, 0, 4'hF);
        check(rd, 0);
        check(port_in_o, pins & 8'h0C);
        check(periph_in_valid_o, 0);
        wb(1, `SPM_OFS_PORT_CTRL, 1, 4'hE);
        wb(0, `SPM_OFS_PORT_CTRL, 0, 4'hF);
        check(rd, 0);
        wb(1, `SPM_OFS_PORT_CTRL, 1, 4'hF);
        repeat (4) @(posedge clk_i);
        check(port_in_o, pins);
        check(periph_in_valid_o, 1);
        serial_mode_i <= 0;
        repeat (4) @(posedge clk_i);
        wb(1, `SPM_OFS_PORT_CTRL, 0, 4'hF);
        serial_mode_i <= 1;
        repeat (4) @(posedge clk_i);
        check(port_in_o, pins);
        wb(0, `SPM_OFS_STATUS, 0, 4'hF);
        check(rd[3:0], 4'h9);
        wb(0, 8'h10, 0, 4'hF);
        check(rd, 0);
        $display("test port control done");
        complete_run();
    end
    // Gating cases take a little over twenty cycles each
    initial begin
        #(25 * 20000);
        fails++;
        complete_run();
    end
endmodule
